// *** design/srl_defines.svh ***
`ifndef SRL_DEFINES_SVH
`define SRL_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SRL_A_DRIVE_HIGH 7'h01
`define SRL_A_DRIVE_TERM 7'h02
`define SRL_A_DRIVE_LOW 7'h03
`define SRL_A_CMP_HIGH 7'h04
`define SRL_A_CMP_LOW 7'h05
`define SRL_A_CLAMP_HIGH 7'h06
`define SRL_A_CLAMP_LOW 7'h07
`define SRL_A_LOAD_SRC 7'h08
`define SRL_A_LOAD_SINK 7'h09
`define SRL_A_PARAM_FORCE 7'h0a
`define SRL_A_HV_OUT 7'h0b
`define SRL_A_OV_HIGH 7'h0c
`define SRL_A_OV_LOW 7'h0d
`define SRL_A_SPARE 7'h0e
`define SRL_A_CONV_CTRL 7'h11
`define SRL_A_SPI_CTRL 7'h12
`define SRL_A_HV_CTRL 7'h18
`define SRL_A_PIN_CTRL 7'h19
`define SRL_A_PARAM_CTRL 7'h1a
`define SRL_A_PMEAS_CTRL 7'h1b
`define SRL_A_CMP_CTRL 7'h1c
`define SRL_A_ALARM_MASK 7'h1d
`define SRL_A_ALARM_STATE 7'h1e

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRL_R_ZERO_VOLT 16'h4000
`define SRL_R_CMP_HIGH 16'h4ccc
`define SRL_R_CMP_LOW 16'h3333
`define SRL_R_FULL 16'hffff
`define SRL_R_EMPTY 16'h0000
`define SRL_R_LOAD 16'h4040
`define SRL_R_HV_OUT 16'h2666
`define SRL_R_PIN_CTRL 16'h0080
`define SRL_R_CMP_CTRL 16'h07fe
`define SRL_R_ALARM_MASK 16'h0045

// ----------------------------------------
// Serial word and timing
// ----------------------------------------
`define SRL_FRAME_BITS 5'h1a
`define SRL_HDR_BITS 5'h0a
`define SRL_SOFT_RESET_BIT 0
`define SRL_RESET_EDGES 64
`define SRL_CLK_NS 50
`define SRL_DEGLITCH_NS 3000
`define SRL_SETTLE_NS 10000
`define SRL_THERMAL_C 8'h64

`endif

// *** design/srl_pkg.sv ***
`include "srl_defines.svh"
package srl_pkg;
    // Reset sequencer phases
    typedef enum logic [2:0] {
        SRL_RUN,
        SRL_STATIC,
        SRL_COUNT,
        SRL_DEGLITCH,
        SRL_SETTLE
    } srl_state_t;

    // Two channels by 32 addresses of 16-bit words
    typedef logic [1:0][31:0][15:0] srl_regs_t;

    // Whole state of the block
    typedef struct packed {
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic sdi_s1;
        logic sdi_s2;
        logic [15:0] alarm_s1;
        logic [15:0] alarm_s2;
        logic [25:0] shift;
        logic [4:0] bitcnt;
        logic hdr_read;
        logic [6:0] hdr_addr;
        logic [1:0] hdr_ch;
        logic [15:0] rdata;
        logic sdo;
        logic sdo_oe;
        logic soft_pend;
        srl_state_t state;
        logic [6:0] cnt;
        logic [7:0] timer;
        logic busy;
        logic grounded;
        logic settled;
        logic units_off;
        logic pin_gnd;
        logic pmu_open;
        logic coeff_clear;
        logic thermal_en;
        logic param_alarm_en;
        logic ovd_alarm_en;
        logic [7:0] thermal_thr;
        srl_regs_t regs;
    } srl_state_s_t;
endpackage : srl_pkg

// *** design/srl_reset_sequencer.sv ***
`timescale 1ns/1ps
`include "srl_defines.svh"
module srl_reset_sequencer
    import srl_pkg::*;
#(
    parameter int RESET_EDGES = `SRL_RESET_EDGES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic [15:0] alarm_flags,
    output logic sdo_out,
    output logic sdo_oe,
    output logic busy_n_out,
    output logic busy_n_oe,
    output logic levels_grounded,
    output logic levels_settled,
    output logic units_disabled,
    output logic measure_switch_open,
    output logic test_pin_soft_ground,
    output logic coeff_clear,
    output logic thermal_alarm_en,
    output logic [7:0] thermal_threshold,
    output logic parametric_alarm_en,
    output logic overvoltage_detect_alarm_en
);

    // ----------------------------------------
    // Timing derived from the clock rate
    // ----------------------------------------
    // Deglitch and settle are approximate, so the floor is taken
    localparam int DEGLITCH_CYC = `SRL_DEGLITCH_NS / `SRL_CLK_NS;
    localparam int SETTLE_CYC = `SRL_SETTLE_NS / `SRL_CLK_NS;
    localparam logic [7:0] DEGLITCH_LAST = 8'(DEGLITCH_CYC - 1);
    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);
    localparam logic [6:0] EDGES_LAST = 7'(RESET_EDGES - 1);

    // Count and timers are sized for these limits
    initial begin
        if (RESET_EDGES < 2 || RESET_EDGES > 127) begin
            $error("RESET_EDGES must lie in 2..127");
        end
        if (SETTLE_CYC > 256 || DEGLITCH_CYC > 256) begin
            $error("timer too narrow for deglitch or settle");
        end
    end

    // ----------------------------------------
    // Default register image
    // ----------------------------------------
    // One place defines every reset value; both resets use it
    function automatic logic [15:0] reg_default(input logic [6:0] a);
        logic [15:0] v;
        v = `SRL_R_EMPTY;
        if (a == `SRL_A_DRIVE_HIGH || a == `SRL_A_DRIVE_TERM || a == `SRL_A_DRIVE_LOW) begin
            v = `SRL_R_ZERO_VOLT;
        end else if (a == `SRL_A_CMP_HIGH) begin
            v = `SRL_R_CMP_HIGH;
        end else if (a == `SRL_A_CMP_LOW) begin
            v = `SRL_R_CMP_LOW;
        end else if (a == `SRL_A_CLAMP_HIGH || a == `SRL_A_OV_HIGH) begin
            v = `SRL_R_FULL;
        end else if (a == `SRL_A_CLAMP_LOW || a == `SRL_A_OV_LOW) begin
            v = `SRL_R_EMPTY;
        end else if (a == `SRL_A_LOAD_SRC || a == `SRL_A_LOAD_SINK) begin
            v = `SRL_R_LOAD;
        end else if (a == `SRL_A_PARAM_FORCE || a == `SRL_A_SPARE) begin
            v = `SRL_R_ZERO_VOLT;
        end else if (a == `SRL_A_HV_OUT) begin
            v = `SRL_R_HV_OUT;
        end else if (a == `SRL_A_PIN_CTRL) begin
            v = `SRL_R_PIN_CTRL;
        end else if (a == `SRL_A_CMP_CTRL) begin
            v = `SRL_R_CMP_CTRL;
        end else if (a == `SRL_A_ALARM_MASK) begin
            v = `SRL_R_ALARM_MASK;
        end
        return v;
    endfunction : reg_default

    // Whole register file at its defaults
    function automatic srl_regs_t regs_default();
        srl_regs_t r;
        for (int c = 0; c < 2; c++) begin
            for (int a = 0; a < 32; a++) begin
                r[c][a] = reg_default(7'(a));
            end
        end
        return r;
    endfunction : regs_default

    // Addresses that software may write
    function automatic logic is_writable(input logic [6:0] a);
        return (a >= `SRL_A_DRIVE_HIGH && a <= `SRL_A_SPARE) ||
               a == `SRL_A_CONV_CTRL || a == `SRL_A_SPI_CTRL ||
               (a >= `SRL_A_HV_CTRL && a <= `SRL_A_ALARM_MASK);
    endfunction : is_writable

    // Addresses with a single chip-wide copy, held in channel 0
    function automatic logic is_chip_wide(input logic [6:0] a);
        return (a >= `SRL_A_HV_OUT && a <= `SRL_A_SPARE) ||
               a == `SRL_A_SPI_CTRL || a == `SRL_A_HV_CTRL;
    endfunction : is_chip_wide

    // ----------------------------------------
    // Reset image of the state
    // ----------------------------------------
    // Asynchronous entry: static reset state, busy driven at once
    function automatic srl_state_s_t state_reset();
        srl_state_s_t s;
        s = '0;
        s.sclk_s1 = 1'b0;
        s.cs_s1 = 1'b1;
        s.cs_s2 = 1'b1;
        s.cs_s3 = 1'b1;
        s.state = SRL_STATIC;
        s.busy = 1'b1;
        s.grounded = 1'b1;
        s.units_off = 1'b1;
        s.pmu_open = 1'b1;
        s.pin_gnd = 1'b1;
        s.coeff_clear = 1'b1;
        s.regs = regs_default();
        return s;
    endfunction : state_reset

    localparam srl_state_s_t RESET_IMAGE = state_reset();

    srl_state_s_t q; // Registered state
    srl_state_s_t nxt_q; // Next state

    logic sclk_rise; // Sampled serial clock rose
    logic sclk_fall; // Sampled serial clock fell
    logic [25:0] shifted; // Frame shift register with the new bit
    logic [4:0] nxt_bitcnt; // Bit count after this edge
    logic [6:0] w_addr; // Address of a completed frame
    logic [1:0] w_ch; // Channel field of a completed frame
    logic [15:0] w_data; // Data of a completed frame

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        nxt_q = q;
        // Pin inputs pass two flops before any logic looks at them
        nxt_q.sclk_s1 = sclk;
        nxt_q.sclk_s2 = q.sclk_s1;
        nxt_q.sclk_s3 = q.sclk_s2;
        nxt_q.cs_s1 = cs_n;
        nxt_q.cs_s2 = q.cs_s1;
        nxt_q.cs_s3 = q.cs_s2;
        nxt_q.sdi_s1 = sdi;
        nxt_q.sdi_s2 = q.sdi_s1;
        nxt_q.alarm_s1 = alarm_flags;
        nxt_q.alarm_s2 = q.alarm_s1;

        sclk_rise = q.sclk_s2 && !q.sclk_s3;
        sclk_fall = !q.sclk_s2 && q.sclk_s3;
        shifted = {q.shift[24:0], q.sdi_s2};
        nxt_bitcnt = q.bitcnt + 5'h01;
        w_addr = shifted[24:18];
        w_ch = shifted[17:16];
        w_data = shifted[15:0];

        // Serial port: frame start on chip select falling
        if (!q.cs_s2 && q.cs_s3) begin
            nxt_q.bitcnt = '0;
            nxt_q.hdr_read = 1'b0;
        end
        // Chip select high releases the shared data line
        if (q.cs_s2) begin
            nxt_q.sdo_oe = 1'b0;
        end

        // Shift in on rising serial clock while selected
        if (sclk_rise && !q.cs_s2 && q.bitcnt < `SRL_FRAME_BITS) begin
            nxt_q.shift = shifted;
            nxt_q.bitcnt = nxt_bitcnt;
            if (nxt_bitcnt == `SRL_HDR_BITS) begin
                // Header done: latch it and fetch read data
                nxt_q.hdr_read = shifted[9];
                nxt_q.hdr_addr = shifted[8:2];
                nxt_q.hdr_ch = shifted[1:0];
                if (shifted[8:2] == `SRL_A_ALARM_STATE) begin
                    nxt_q.rdata = q.alarm_s2;
                end else if (shifted[8:7] != 2'b00) begin
                    nxt_q.rdata = '0;
                end else if (is_chip_wide(shifted[8:2]) || shifted[0]) begin
                    nxt_q.rdata = q.regs[0][shifted[6:2]];
                end else begin
                    nxt_q.rdata = q.regs[1][shifted[6:2]];
                end
            end
            // Writes are refused while the reset sequence owns the registers
            if (nxt_bitcnt == `SRL_FRAME_BITS && !shifted[25] &&
                    is_writable(w_addr) && q.state != SRL_STATIC &&
                    q.state != SRL_COUNT) begin
                if (is_chip_wide(w_addr)) begin
                    if (w_ch[0]) begin
                        nxt_q.regs[0][w_addr[4:0]] = w_data;
                    end
                end else begin
                    if (w_ch[0]) begin
                        nxt_q.regs[0][w_addr[4:0]] = w_data;
                    end
                    if (w_ch[1]) begin
                        nxt_q.regs[1][w_addr[4:0]] = w_data;
                    end
                end
                if (w_addr == `SRL_A_SPI_CTRL && w_ch[0] &&
                        w_data[`SRL_SOFT_RESET_BIT]) begin
                    nxt_q.soft_pend = 1'b1;
                end
            end
        end

        // Read data leaves on falling serial clock after the header
        if (sclk_fall && !q.cs_s2 && q.hdr_read && q.bitcnt >= `SRL_HDR_BITS) begin
            nxt_q.sdo = q.rdata[15];
            nxt_q.rdata = {q.rdata[14:0], 1'b0};
            nxt_q.sdo_oe = 1'b1;
        end

        // Reset sequencer
        if (q.soft_pend && sclk_rise && q.cs_s2) begin
            // First edge after release: same actions as the pin reset, except that thermal_thr keeps its value
            nxt_q.soft_pend = 1'b0;
            nxt_q.busy = 1'b1;
            nxt_q.regs = regs_default();
            nxt_q.coeff_clear = 1'b1;
            nxt_q.grounded = 1'b1;
            nxt_q.settled = 1'b0;
            nxt_q.units_off = 1'b1;
            nxt_q.pmu_open = 1'b1;
            nxt_q.pin_gnd = 1'b1;
            nxt_q.thermal_en = 1'b0;
            nxt_q.param_alarm_en = 1'b0;
            nxt_q.ovd_alarm_en = 1'b0;
            nxt_q.cnt = '0;
            nxt_q.state = SRL_STATIC;
        end else begin
            case (q.state)
                SRL_STATIC: begin
                    // Stays here until a serial clock edge arrives
                    if (sclk_rise) begin
                        nxt_q.cnt = 7'h01;
                        nxt_q.state = SRL_COUNT;
                        nxt_q.bitcnt = '0;
                        nxt_q.hdr_read = 1'b0;
                        nxt_q.regs = regs_default();
                        nxt_q.coeff_clear = 1'b0;
                        nxt_q.thermal_en = 1'b1;
                        nxt_q.thermal_thr = `SRL_THERMAL_C;
                        nxt_q.param_alarm_en = 1'b0;
                        nxt_q.ovd_alarm_en = 1'b0;
                    end
                end
                SRL_COUNT: begin
                    // Busy holds until the last counted edge
                    if (sclk_rise) begin
                        nxt_q.cnt = q.cnt + 7'h01;
                        if (q.cnt == EDGES_LAST) begin
                            nxt_q.busy = 1'b0;
                            nxt_q.units_off = 1'b0;
                            nxt_q.pmu_open = 1'b0;
                            nxt_q.pin_gnd = 1'b0;
                            nxt_q.timer = '0;
                            nxt_q.state = SRL_DEGLITCH;
                        end
                    end
                end
                SRL_DEGLITCH: begin
                    // Self-timed on the system clock, no serial clock needed
                    nxt_q.timer = q.timer + 8'h01;
                    if (q.timer == DEGLITCH_LAST) begin
                        nxt_q.grounded = 1'b0;
                        nxt_q.timer = '0;
                        nxt_q.state = SRL_SETTLE;
                    end
                end
                SRL_SETTLE: begin
                    nxt_q.timer = q.timer + 8'h01;
                    if (q.timer == SETTLE_LAST) begin
                        nxt_q.settled = 1'b1;
                        nxt_q.state = SRL_RUN;
                    end
                end
                default: begin
                    // Normal operation
                end
            endcase
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // The pin reset loads the default image with no clock at all
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= RESET_IMAGE;
        end else begin
            q <= nxt_q;
        end
    end

    // ----------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------
    assign sdo_out = q.sdo;
    assign sdo_oe = q.sdo_oe;
    assign busy_n_out = 1'b0 & q.busy;
    assign busy_n_oe = q.busy;
    assign levels_grounded = q.grounded;
    assign levels_settled = q.settled;
    assign units_disabled = q.units_off;
    assign measure_switch_open = q.pmu_open;
    assign test_pin_soft_ground = q.pin_gnd;
    assign coeff_clear = q.coeff_clear;
    assign thermal_alarm_en = q.thermal_en;
    assign thermal_threshold = q.thermal_thr;
    assign parametric_alarm_en = q.param_alarm_en;
    assign overvoltage_detect_alarm_en = q.ovd_alarm_en;

endmodule : srl_reset_sequencer

// *** tb/srl_reset_monitor.sv ***
`timescale 1ns/1ps
module srl_reset_monitor
    import srl_pkg::*;
#(
    parameter int RESET_EDGES = 64
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sclk,
    input wire logic busy_n_out,
    input wire logic busy_n_oe,
    input wire logic levels_grounded,
    input wire logic levels_settled,
    input wire logic units_disabled,
    input wire logic measure_switch_open,
    input wire logic test_pin_soft_ground,
    input wire logic coeff_clear,
    input wire logic thermal_alarm_en,
    input wire logic [7:0] thermal_threshold,
    input wire logic parametric_alarm_en,
    input wire logic overvoltage_detect_alarm_en
);
    // ----------------------------------------
    // Serial clock rises seen while busy
    // ----------------------------------------
    logic sclk_ff;
    logic [7:0] edge_cnt_ff;

    // Raw rises, so a slow sync inside the block cannot hide a short count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sclk_ff <= 1'b0;
            edge_cnt_ff <= 8'h00;
        end else begin
            sclk_ff <= sclk;
            if (!busy_n_oe) begin
                edge_cnt_ff <= 8'h00;
            end else if (sclk && !sclk_ff) begin
                edge_cnt_ff <= edge_cnt_ff + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_release_state: assert property (
        $rose(nrst) |-> busy_n_oe && levels_grounded && coeff_clear && units_disabled
            && measure_switch_open && test_pin_soft_ground)
        else $error("static state missing after reset release");
    a_busy_pin_low: assert property (busy_n_oe |-> !busy_n_out)
        else $error("busy pin not pulled low");
    a_busy_count: assert property (
        $fell(busy_n_oe) |-> edge_cnt_ff == RESET_EDGES[7:0])
        else $error("busy released after wrong edge count");
    a_held_busy: assert property (
        busy_n_oe |-> levels_grounded && units_disabled && measure_switch_open
            && test_pin_soft_ground)
        else $error("outputs released while busy");
    a_thermal_cfg: assert property (
        $rose(thermal_alarm_en) |-> busy_n_oe && thermal_threshold == 8'h64
            && !parametric_alarm_en && !overvoltage_detect_alarm_en)
        else $error("alarm setup wrong");
    a_deglitch_len: assert property (
        $fell(busy_n_oe) |-> ##[57:63] $fell(levels_grounded))
        else $error("deglitch interval wrong");
    a_settle_len: assert property (
        $fell(levels_grounded) |-> ##[197:203] $rose(levels_settled))
        else $error("settle interval wrong");
    a_settled_state: assert property (
        levels_settled |-> !levels_grounded && !busy_n_oe)
        else $error("settled during reset");
    a_coeff_static: assert property (
        coeff_clear |-> busy_n_oe && !thermal_alarm_en)
        else $error("coefficients held outside static state");

    c_busy_free: cover property ($fell(busy_n_oe));
    c_soft_start: cover property ($rose(busy_n_oe));
    c_settled: cover property ($rose(levels_settled));
endmodule : srl_reset_monitor

bind srl_reset_sequencer srl_reset_monitor #(.RESET_EDGES(RESET_EDGES)) mon_u (
    .clk(clk), .nrst(nrst), .sclk(sclk), .busy_n_out(busy_n_out), .busy_n_oe(busy_n_oe),
    .levels_grounded(levels_grounded), .levels_settled(levels_settled),
    .units_disabled(units_disabled), .measure_switch_open(measure_switch_open),
    .test_pin_soft_ground(test_pin_soft_ground), .coeff_clear(coeff_clear),
    .thermal_alarm_en(thermal_alarm_en), .thermal_threshold(thermal_threshold),
    .parametric_alarm_en(parametric_alarm_en),
    .overvoltage_detect_alarm_en(overvoltage_detect_alarm_en)
);

// *** tb/srl_host_model.sv ***
`timescale 1ns/1ps
module srl_host_model (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_out
);
    // Idle: link clock still, chip deselected
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // Half of a 400 ns link period
    task automatic half_period();
        repeat (4) @(posedge clk);
    endtask : half_period

    // Rises with chip select high; the reset count needs them
    task automatic pulses(input int n);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            sclk <= 1'b1;
            half_period();
            sclk <= 1'b0;
            half_period();
        end
    endtask : pulses

    // One 26-bit word, first bit first; read data taken at each of the 16 data-bit rises
    task automatic frame(input logic rw, input logic [6:0] addr, input logic [1:0] ch,
        input logic [15:0] data, output logic [15:0] rd);
        logic [25:0] word;
        word = {rw, addr, ch, data};
        rd = 16'h0000;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 25; i >= 0; i--) begin
            sdi <= word[i];
            half_period();
            sclk <= 1'b1;
            if (i < 16) begin
                rd[i] = sdo_out;
            end
            half_period();
            sclk <= 1'b0;
        end
        half_period();
        cs_n <= 1'b1;
        // Released line must not keep looking valid
        sdi <= ~word[0];
    endtask : frame
endmodule : srl_host_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "srl_defines.svh"
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module testbench;
    import srl_pkg::*;
    // Short count keeps the run brief
    localparam int EDGES = 4;
    logic clk, nrst, sclk, cs_n, sdi, sdo_out, sdo_oe, busy_n_out, busy_n_oe;
    logic levels_grounded, levels_settled, units_disabled, measure_switch_open;
    logic test_pin_soft_ground, coeff_clear, thermal_alarm_en, parametric_alarm_en;
    logic overvoltage_detect_alarm_en;
    logic [7:0] thermal_threshold;
    logic [15:0] alarm_flags;
    int miscompares, num_checks;
    // Expected map after any reset; 0x0f and 0x13 are unmapped
    logic [6:0] def_addr [24] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
        7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h11, 7'h12, 7'h13,
        7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d};
    logic [15:0] def_val [24] = '{16'h4000, 16'h4000, 16'h4000, 16'h4ccc, 16'h3333,
        16'hffff, 16'h0000, 16'h4040, 16'h4040, 16'h4000, 16'h2666, 16'hffff, 16'h0000,
        16'h4000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0080, 16'h0000,
        16'h0000, 16'h07fe, 16'h0045};

    srl_reset_sequencer #(.RESET_EDGES(EDGES)) dut_u (.clk, .nrst, .sclk, .cs_n, .sdi,
        .alarm_flags, .sdo_out, .sdo_oe, .busy_n_out, .busy_n_oe, .levels_grounded,
        .levels_settled, .units_disabled, .measure_switch_open, .test_pin_soft_ground,
        .coeff_clear, .thermal_alarm_en, .thermal_threshold, .parametric_alarm_en,
        .overvoltage_detect_alarm_en);
    srl_host_model host_u (.clk, .sclk, .cs_n, .sdi, .sdo_out);

    always #25 clk = ~clk;

    task automatic reg_rd(input logic [6:0] a, input logic [1:0] ch, output logic [15:0] v);
        host_u.frame(1'b1, a, ch, 16'h0000, v);
    endtask : reg_rd
    task automatic reg_wr(input logic [6:0] a, input logic [1:0] ch, input logic [15:0] d);
        logic [15:0] unused;
        host_u.frame(1'b0, a, ch, d, unused);
    endtask : reg_wr

    // Static state, then the counted phase and the analog timers
    task automatic t_hard_reset();
        repeat (20) @(negedge clk);
        `CHK("busy", 1'b1, busy_n_oe)
        `CHK("ground", 1'b1, levels_grounded)
        `CHK("units", 1'b1, units_disabled)
        `CHK("switch", 1'b1, measure_switch_open)
        `CHK("pin", 1'b1, test_pin_soft_ground)
        `CHK("coeff", 1'b1, coeff_clear)
        `CHK("static", 1'b0, thermal_alarm_en)
        host_u.pulses(EDGES - 1);
        @(negedge clk);
        `CHK("busy early", 1'b1, busy_n_oe)
        `CHK("thermal", 1'b1, thermal_alarm_en)
        `CHK("threshold", 8'h64, thermal_threshold)
        `CHK("param alarm", 1'b0, parametric_alarm_en)
        `CHK("ovd alarm", 1'b0, overvoltage_detect_alarm_en)
        host_u.pulses(1);
        @(negedge clk);
        `CHK("busy free", 1'b0, busy_n_oe)
        `CHK("deglitch", 1'b1, levels_grounded)
        repeat (70) @(negedge clk);
        `CHK("ground free", 1'b0, levels_grounded)
        repeat (210) @(negedge clk);
        `CHK("settled", 1'b1, levels_settled)
    endtask : t_hard_reset

    task automatic t_defaults();
        logic [15:0] v;
        for (int i = 0; i < 24; i++) begin
            reg_rd(def_addr[i], 2'b01, v);
            `CHK("default", def_val[i], v)
        end
    endtask : t_defaults

    // Drive high written to both channels and read back through the second; read-only refuses
    task automatic t_write();
        logic [15:0] v;
        reg_wr(`SRL_A_DRIVE_HIGH, 2'b11, 16'h1234);
        reg_wr(`SRL_A_CMP_CTRL, 2'b01, 16'h0aaa);
        reg_wr(`SRL_A_ALARM_STATE, 2'b01, 16'hffff);
        reg_rd(`SRL_A_DRIVE_HIGH, 2'b10, v);
        `CHK("written", 16'h1234, v)
        reg_rd(`SRL_A_CMP_CTRL, 2'b01, v);
        `CHK("ctrl", 16'h0aaa, v)
        reg_rd(`SRL_A_ALARM_STATE, 2'b01, v);
        `CHK("alarm", 16'h00a5, v)
        // Alarm input moves, so the read path is proven live
        @(posedge clk);
        alarm_flags <= 16'h5a5a;
        reg_rd(`SRL_A_ALARM_STATE, 2'b10, v);
        `CHK("alarm new", 16'h5a5a, v)
        repeat (4) @(negedge clk);
        `CHK("sdo release", 1'b0, sdo_oe)
    endtask : t_write

    task automatic t_soft_reset();
        reg_wr(`SRL_A_SPI_CTRL, 2'b01, 16'h0001);
        repeat (10) @(negedge clk);
        `CHK("no edge yet", 1'b0, busy_n_oe)
        host_u.pulses(1);
        @(negedge clk);
        `CHK("soft busy", 1'b1, busy_n_oe)
        `CHK("soft ground", 1'b1, levels_grounded)
        `CHK("soft units", 1'b1, units_disabled)
        `CHK("soft pin", 1'b1, test_pin_soft_ground)
        `CHK("soft coeff", 1'b1, coeff_clear)
        `CHK("soft static", 1'b0, thermal_alarm_en)
        host_u.pulses(1);
        @(negedge clk);
        `CHK("soft count", 1'b1, thermal_alarm_en)
        host_u.pulses(EDGES - 2);
        @(negedge clk);
        `CHK("soft early", 1'b1, busy_n_oe)
        host_u.pulses(1);
        @(negedge clk);
        `CHK("soft free", 1'b0, busy_n_oe)
        repeat (300) @(posedge clk);
    endtask : t_soft_reset

    // Hard reset in mid count restarts it from zero
    task automatic t_restart();
        reg_wr(`SRL_A_SPI_CTRL, 2'b01, 16'h0001);
        host_u.pulses(3);
        @(posedge clk);
        nrst <= 1'b0;
        @(negedge clk);
        `CHK("async busy", 1'b1, busy_n_oe)
        `CHK("async alarm", 1'b0, thermal_alarm_en)
        @(posedge clk);
        nrst <= 1'b1;
        host_u.pulses(EDGES - 1);
        @(negedge clk);
        `CHK("restart", 1'b1, busy_n_oe)
        host_u.pulses(1);
        @(negedge clk);
        `CHK("restart free", 1'b0, busy_n_oe)
        repeat (300) @(posedge clk);
    endtask : t_restart

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Run is about 13k cycles; 40k cuts a hang
    initial begin
        #2000000;
        miscompares++;
        finish_test();
    end

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        alarm_flags = 16'h00a5;
        miscompares = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        t_hard_reset();
        t_defaults();
        t_write();
        t_soft_reset();
        t_defaults();
        t_restart();
        finish_test();
    end
endmodule : testbench
